// File: design/hms_sequencer.sv
// Behaviour
// - reset pin low standby, high hub
// - standby powers off regulators, pll, core
// - reset disables ports, clears registers, halts pll
// - init stage loads rom defaults
// - init enables regulator, latches select inputs
// - init ends after time, port closed
// - wait for pll lock, port closed
// - config stage accepts serial register writes
// - hold low means config timeout ends stage
// - hold high waits until host clears it
// - connect passes or waits for handshake
// - handshake connects within ten microseconds
// - comm stays until reset pin low
// - serial port unusable in comm stage
// - interrupt high picks primary frequencies
// - interrupt low picks secondary frequencies
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
module hms_sequencer #(
  parameter int unsigned INIT_CYCLES = hms_pkg::INIT_CYCLES,
  parameter int unsigned CFG_CYCLES = hms_pkg::CFG_CYCLES,
  parameter logic CFG_HOLD_DEFAULT = 1'b0
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  // hub pins
  input wire logic HUB_RESET_N_I,
  input wire logic PLL_LOCK_I,
  input wire logic [1:0] REF_SEL_I,
  input wire logic INT_N_I,
  // power and core controls
  output logic CORE_REG_EN_O,
  output logic PLL_EN_O,
  output logic CORE_RESET_O,
  output logic ROM_LOAD_O,
  output logic PORTS_EN_O,
  output logic SERIAL_PORT_OPEN_O,
  output logic [15:0] REF_FREQ_KHZ_O,
  output logic [2:0] STAGE_O,
  // axi4-lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // pin synchronisers, first stage read only by second
  // a second flop gives metastability a full cycle to resolve
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic hub_rst_n;
  logic pll_lock;
  logic [1:0] ref_sel;
  logic int_n;
  // stage state
  // cnt_reg counts down; zero ends a timed stage
  hms_pkg::hms_stage_t stage_reg;
  hms_pkg::hms_stage_t stage_next;
  logic [31:0] cnt_reg;
  logic cnt_zero;
  // control and latched strap state
  // secondary_reg set when the interrupt pin was low during init
  logic cfg_hold_reg;
  logic conn_wait_reg;
  logic conn_go_reg;
  logic [1:0] sel_reg;
  logic secondary_reg;
  // axi capture
  // address and data may arrive in either order
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic port_open;
  logic [31:0] status_word;

  // control bits all sit in byte lane 0, so only that strobe matters
  // a write without lane 0 leaves the control bits alone
  function automatic logic ctrl_hit(input logic [7:0] addr, input logic [3:0] strb);
    ctrl_hit = (addr == hms_pkg::ADDR_CTRL) && strb[0];
  endfunction

  // synchronised pin levels
  // sync flops reset low, so the stage machine starts in standby
  assign hub_rst_n = pin_sync_reg[0];
  assign pll_lock = pin_sync_reg[1];
  assign ref_sel = pin_sync_reg[3:2];
  assign int_n = pin_sync_reg[4];

  // two-flop synchroniser for all pins
  // straps cross as loose bits; they are only used after init has run
  // for many cycles, so any skew between bits has settled long before
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {INT_N_I, REF_SEL_I, PLL_LOCK_I, HUB_RESET_N_I};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // port is usable only in config and connect; closed in init, wait, comm
  // a closed port still answers every request, so a host never hangs
  assign port_open = (stage_reg == hms_pkg::ST_CONFIG) ||
                     (stage_reg == hms_pkg::ST_CONNECT);
  assign cnt_zero = (cnt_reg == 32'h0000_0000);

  // stage transitions
  always_comb begin
    stage_next = stage_reg;
    case (stage_reg)
      hms_pkg::ST_STANDBY: begin
        // only the synced reset pin is watched here
        if (hub_rst_n) stage_next = hms_pkg::ST_INIT;
      end
      hms_pkg::ST_INIT: begin
        // a clock already locked skips the wait stage entirely
        if (cnt_zero && pll_lock) stage_next = hms_pkg::ST_CONFIG;
        else if (cnt_zero) stage_next = hms_pkg::ST_WAIT_CLOCK;
      end
      hms_pkg::ST_WAIT_CLOCK: begin
        // no time limit: a missing reference clock parks the hub here
        if (pll_lock) stage_next = hms_pkg::ST_CONFIG;
      end
      hms_pkg::ST_CONFIG: begin
        // held config has no time limit
        if (!cfg_hold_reg && cnt_zero) stage_next = hms_pkg::ST_CONNECT;
      end
      hms_pkg::ST_CONNECT: begin
        // handshake is a level bit, acted on the cycle after the write
        if (!conn_wait_reg || conn_go_reg) stage_next = hms_pkg::ST_COMM;
      end
      // only the reset pin leaves comm, handled below
      hms_pkg::ST_COMM: stage_next = hms_pkg::ST_COMM;
      default: stage_next = hms_pkg::ST_STANDBY;
    endcase
    // reset pin beats every other transition
    if (!hub_rst_n) stage_next = hms_pkg::ST_STANDBY;
  end

  // stage register
  // binary codes double as the stage output and status encoding
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) stage_reg <= hms_pkg::ST_STANDBY;
    else stage_reg <= stage_next;
  end

  // stage timer, loaded on entry to timed stages
  // one counter serves init and config; the other stages are untimed
  // loading count minus one makes a stage last exactly count cycles
  // 32 bits hold the full config timeout at the system clock rate
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cnt_reg <= 32'h0000_0000;
    end else if (stage_next != stage_reg) begin
      if (stage_next == hms_pkg::ST_INIT) cnt_reg <= INIT_CYCLES - 32'd1;
      else if (stage_next == hms_pkg::ST_CONFIG) cnt_reg <= CFG_CYCLES - 32'd1;
      else cnt_reg <= 32'h0000_0000;
    end else if (!cnt_zero) begin
      cnt_reg <= cnt_reg - 32'd1;
    end
  end

  // straps latched during init from synchronised pins
  // reloaded every init cycle, so the value at the end of init wins
  // limitation: a strap that moves after init is not seen until the next init stage
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sel_reg <= 2'h0;
      secondary_reg <= 1'b0;
    end else if (stage_reg == hms_pkg::ST_INIT) begin
      sel_reg <= ref_sel;
      secondary_reg <= !int_n;
    end
  end

  // control bits; reset stage wipes them back to defaults
  // nothing survives standby, so the host rewrites after every reset
  // closed port ignores control writes, matching its slverr answer
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cfg_hold_reg <= 1'b0;
      conn_wait_reg <= 1'b0;
      conn_go_reg <= 1'b0;
    end else if (stage_reg == hms_pkg::ST_STANDBY || stage_reg == hms_pkg::ST_INIT) begin
      cfg_hold_reg <= CFG_HOLD_DEFAULT;
      conn_wait_reg <= hms_pkg::CTRL_RESET[hms_pkg::CTRL_CONN_WAIT];
      conn_go_reg <= 1'b0;
    end else if (do_write && port_open && ctrl_hit(aw_addr_reg, w_strb_reg)) begin
      cfg_hold_reg <= w_data_reg[hms_pkg::CTRL_CFG_HOLD];
      conn_wait_reg <= w_data_reg[hms_pkg::CTRL_CONN_WAIT];
      conn_go_reg <= w_data_reg[hms_pkg::CTRL_CONN_GO];
    end
  end

  // power and core outputs follow stage
  // fed from stage_next so each output lines up with the stage register
  // trade-off: decode sits in front of the flops, not behind them
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CORE_REG_EN_O <= 1'b0;
      PLL_EN_O <= 1'b0;
      CORE_RESET_O <= 1'b1;
      ROM_LOAD_O <= 1'b0;
      PORTS_EN_O <= 1'b0;
    end else begin
      CORE_REG_EN_O <= stage_next != hms_pkg::ST_STANDBY;
      PLL_EN_O <= stage_next != hms_pkg::ST_STANDBY;
      CORE_RESET_O <= stage_next == hms_pkg::ST_STANDBY;
      ROM_LOAD_O <= stage_next == hms_pkg::ST_INIT;
      PORTS_EN_O <= stage_next == hms_pkg::ST_COMM;
    end
  end

  // frequency lookup from latched straps
  // registered so the output never glitches while straps are relatched
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REF_FREQ_KHZ_O <= 16'h0000;
    end else if (!secondary_reg) begin
      case (sel_reg)
        2'h0: REF_FREQ_KHZ_O <= hms_pkg::FREQ_PRI_0;
        2'h1: REF_FREQ_KHZ_O <= hms_pkg::FREQ_PRI_1;
        2'h2: REF_FREQ_KHZ_O <= hms_pkg::FREQ_PRI_2;
        default: REF_FREQ_KHZ_O <= hms_pkg::FREQ_PRI_3;
      endcase
    end else begin
      case (sel_reg)
        2'h0: REF_FREQ_KHZ_O <= hms_pkg::FREQ_SEC_0;
        2'h1: REF_FREQ_KHZ_O <= hms_pkg::FREQ_SEC_1;
        2'h2: REF_FREQ_KHZ_O <= hms_pkg::FREQ_SEC_2;
        default: REF_FREQ_KHZ_O <= hms_pkg::FREQ_SEC_3;
      endcase
    end
  end

  assign STAGE_O = stage_reg;
  assign SERIAL_PORT_OPEN_O = port_open;

  // axi write: address and data taken in either order, then response
  // each channel holds one item; a second one waits on ready
  assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
  assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID;

  // write capture
  // set and clear never meet: ready is low while an item is held
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // write response; closed port or unmapped address gives slverr
  // status is read only; a write to it is dropped and answered okay
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= hms_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (port_open && aw_addr_reg == hms_pkg::ADDR_CTRL)
        S_AXI_BRESP <= hms_pkg::RESP_OKAY;
      else if (aw_addr_reg == hms_pkg::ADDR_STATUS) S_AXI_BRESP <= hms_pkg::RESP_OKAY;
      else S_AXI_BRESP <= hms_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // status word shows live stage and latched straps
  // unused bits read zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[hms_pkg::STAT_STAGE_LSB +: 3] = stage_reg;
    status_word[hms_pkg::STAT_SEL_LSB +: 2] = sel_reg;
    status_word[hms_pkg::STAT_SECONDARY] = secondary_reg;
    status_word[hms_pkg::STAT_PORT_OPEN] = port_open;
  end

  // one read at a time: address refused while the answer stands
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // read channel; status always readable so software can watch stages
  // unmapped reads give slverr with zero data
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= hms_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= hms_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        hms_pkg::ADDR_CTRL: S_AXI_RDATA <= {29'h0, conn_go_reg, conn_wait_reg, cfg_hold_reg};
        hms_pkg::ADDR_STATUS: S_AXI_RDATA <= status_word;
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= hms_pkg::RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule // hms_sequencer

// File: design/hms_pkg.sv
package hms_pkg;
  // clock rate of the sequencer
  localparam int unsigned CLK_HZ = 200_000_000;
  // stage times, printed figures in their own units
  localparam int unsigned T_INIT_TYP_MS = 3;
  localparam int unsigned T_CFG_MIN_MS = 94;
  localparam int unsigned T_CONNECT_MAX_US = 10;
  localparam int unsigned T_RESET_MIN_US = 100;
  // derived cycle counts
  localparam int unsigned INIT_CYCLES = T_INIT_TYP_MS * (CLK_HZ / 1000);
  localparam int unsigned CFG_CYCLES = T_CFG_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned CONNECT_CYCLES = T_CONNECT_MAX_US * (CLK_HZ / 1_000_000);
  // axi register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  // control register fields
  localparam int unsigned CTRL_CFG_HOLD = 0;
  localparam int unsigned CTRL_CONN_WAIT = 1;
  localparam int unsigned CTRL_CONN_GO = 2;
  // control reset value: hold low, connect wait low
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status register fields
  localparam int unsigned STAT_STAGE_LSB = 0;
  localparam int unsigned STAT_SEL_LSB = 4;
  localparam int unsigned STAT_SECONDARY = 6;
  localparam int unsigned STAT_PORT_OPEN = 7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // frequency codes, kHz
  localparam logic [15:0] FREQ_PRI_0 = 16'h9600;
  localparam logic [15:0] FREQ_PRI_1 = 16'h6590;
  localparam logic [15:0] FREQ_PRI_2 = 16'h4B00;
  localparam logic [15:0] FREQ_PRI_3 = 16'h2EE0;
  localparam logic [15:0] FREQ_SEC_0 = 16'h5DC0;
  localparam logic [15:0] FREQ_SEC_1 = 16'h6978;
  localparam logic [15:0] FREQ_SEC_2 = 16'h61A8;
  localparam logic [15:0] FREQ_SEC_3 = 16'hC350;
  // hub stages
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_INIT = 3'b001,
    ST_WAIT_CLOCK = 3'b010,
    ST_CONFIG = 3'b011,
    ST_CONNECT = 3'b100,
    ST_COMM = 3'b101
  } hms_stage_t;
endpackage

// File: testbench/hms_seq_monitor.sv
module hms_seq_monitor #(
  parameter int unsigned INIT_CYCLES = 20
) (
  // clock, reset, pin
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic HUB_RESET_N_I,
  input wire logic PLL_LOCK_I,
  // stage and controls
  input wire logic [2:0] STAGE_O,
  input wire logic CORE_RESET_O,
  input wire logic PLL_EN_O,
  input wire logic PORTS_EN_O,
  input wire logic SERIAL_PORT_OPEN_O,
  // bus answers
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // cycles spent in init
  int unsigned init_cnt_reg;
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) init_cnt_reg <= 0;
    else init_cnt_reg <= (STAGE_O == 3'h1) ? init_cnt_reg + 1 : 0;
  end
  // pin high long enough to cross the synchroniser
  sequence pin_high_s;
    HUB_RESET_N_I [*3];
  endsequence
  standby_power_a: assert property ($stable(STAGE_O) && STAGE_O == 3'h0
    |-> CORE_RESET_O && !PLL_EN_O) else $error("standby power wrong");
  ports_comm_a: assert property ($stable(STAGE_O)
    |-> PORTS_EN_O == (STAGE_O == 3'h5)) else $error("port enable wrong");
  port_open_a: assert property (
    SERIAL_PORT_OPEN_O == (STAGE_O inside {3'h3, 3'h4})) else $error("port gate wrong");
  pin_low_a: assert property ($fell(HUB_RESET_N_I)
    |-> ##[1:5] STAGE_O == 3'h0) else $error("no standby");
  stage_step_a: assert property (STAGE_O != $past(STAGE_O)
    |-> STAGE_O == 3'h0 || STAGE_O == $past(STAGE_O) + 3'h1
    || (STAGE_O == 3'h3 && $past(STAGE_O) == 3'h1)) else $error("stage order wrong");
  init_len_a: assert property ($past(STAGE_O) == 3'h1 && STAGE_O inside {3'h2, 3'h3}
    |-> init_cnt_reg inside {[INIT_CYCLES - 1:INIT_CYCLES + 1]}) else $error("init length");
  wait_skip_a: assert property (PLL_LOCK_I [*3] ##0 STAGE_O == 3'h1
    |=> STAGE_O != 3'h2) else $error("paused without need");
  comm_stay_a: assert property (pin_high_s ##0 STAGE_O == 3'h5
    |=> STAGE_O == 3'h5) else $error("left comm");
  b_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID) else $error("write answer repeated");
  r_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY
    |=> !S_AXI_RVALID) else $error("read answer repeated");
endmodule // hms_seq_monitor

bind hms_sequencer hms_seq_monitor #(.INIT_CYCLES(INIT_CYCLES)) hms_seq_monitor_i (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .HUB_RESET_N_I(HUB_RESET_N_I),
  .PLL_LOCK_I(PLL_LOCK_I),
  .STAGE_O(STAGE_O), .CORE_RESET_O(CORE_RESET_O), .PLL_EN_O(PLL_EN_O),
  .PORTS_EN_O(PORTS_EN_O), .SERIAL_PORT_OPEN_O(SERIAL_PORT_OPEN_O),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// File: testbench/hms_host_model.sv
module hms_host_model (
  // clock
  input wire logic clk_i,
  // write side
  output logic [7:0] awa_o,
  output logic awv_o,
  input wire logic awr_i,
  output logic [31:0] wd_o,
  output logic wv_o,
  input wire logic wr_i,
  input wire logic [1:0] br_i,
  input wire logic bv_i,
  output logic brd_o,
  // read side
  output logic [7:0] ara_o,
  output logic arv_o,
  input wire logic arr_i,
  input wire logic [31:0] rd_i,
  input wire logic [1:0] rr_i,
  input wire logic rv_i,
  output logic rrd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial {awa_o, awv_o, wd_o, wv_o, brd_o, ara_o, arv_o, rrd_o} = '0;
  // one write; callers also use it in closed stages to check the slverr answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    @(posedge clk_i);
    {awa_o, wd_o} <= {a, d};
    {awv_o, wv_o, brd_o} <= 3'h7;
    forever begin
      @(posedge clk_i);
      // each channel drops only once taken
      if (awr_i) awv_o <= 1'h0;
      if (wr_i) wv_o <= 1'h0;
      if (bv_i) begin
        rsp = br_i;
        brd_o <= 1'h0;
        break;
      end
    end
  endtask
  // one read; may come while connect waits
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge clk_i);
    ara_o <= a;
    {arv_o, rrd_o} <= 2'h3;
    forever begin
      @(posedge clk_i);
      if (arr_i) arv_o <= 1'h0;
      if (rv_i) begin
        {rsp, d} = {rr_i, rd_i};
        rrd_o <= 1'h0;
        break;
      end
    end
  endtask
endmodule // hms_host_model

// File: testbench/hms_sequencer_tb_top.sv
module hms_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
  // short counts keep the run brief
  localparam int unsigned IC = 20;
  localparam int unsigned CC = 40;
  // full minimum reset pulse; later pulses are short to keep the run brief
  localparam int unsigned RL = hms_pkg::T_RESET_MIN_US * (hms_pkg::CLK_HZ / 1_000_000);
  logic clk = 1'h0, rstn = 1'h0, hub_n = 1'h0, lock = 1'h0, int_n = 1'h1;
  logic [1:0] sel = 2'h0, rsp, br, rr;
  logic reg_en, pll_en, core_rst, rom_ld, ports_en, open;
  logic [15:0] freq;
  logic [2:0] stage;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic awv, awr, wv, wr, bv, brd, arv, arr, rv, rrd;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  hms_sequencer #(.INIT_CYCLES(IC), .CFG_CYCLES(CC)) hms_sequencer_i (
    .CLK_SYS_I(clk), .RESETN_I(rstn), .HUB_RESET_N_I(hub_n), .PLL_LOCK_I(lock),
    .REF_SEL_I(sel), .INT_N_I(int_n), .CORE_REG_EN_O(reg_en), .PLL_EN_O(pll_en),
    .CORE_RESET_O(core_rst), .ROM_LOAD_O(rom_ld), .PORTS_EN_O(ports_en),
    .SERIAL_PORT_OPEN_O(open), .REF_FREQ_KHZ_O(freq), .STAGE_O(stage),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rrd));
  hms_host_model hms_host_model_i (.clk_i(clk), .awa_o(awa), .awv_o(awv), .awr_i(awr),
    .wd_o(wd), .wv_o(wv), .wr_i(wr), .br_i(br), .bv_i(bv), .brd_o(brd), .ara_o(ara),
    .arv_o(arv), .arr_i(arr), .rd_i(rdat), .rr_i(rr), .rv_i(rv), .rrd_o(rrd));
  // expected reference frequency in kHz
  function automatic logic [15:0] ef(input logic s, input logic [1:0] c);
    logic [15:0] t [8];
    t = '{hms_pkg::FREQ_PRI_0, hms_pkg::FREQ_PRI_1, hms_pkg::FREQ_PRI_2, hms_pkg::FREQ_PRI_3,
      hms_pkg::FREQ_SEC_0, hms_pkg::FREQ_SEC_1, hms_pkg::FREQ_SEC_2, hms_pkg::FREQ_SEC_3};
    return t[{s, c}];
  endfunction
  // verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for a stage, then let outputs settle
  task automatic wait_st(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    while (stage !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK("stage", s, stage)
    repeat (2) @(posedge clk);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    int dly;
    logic sec;
    void'($urandom(32'hF194));
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // every select code, both tables; odd runs hold config and wait in connect
    for (int i = 0; i < 8; i++) begin
      sec = i[2];
      dly = $urandom_range(0, 6);
      repeat ((i == 0) ? RL : 12) @(posedge clk); // pin low long enough
      `CHK("core_rst", 1'h1, core_rst)
      `CHK("power", 2'h0, {reg_en, pll_en})
      `CHK("ports", 1'h0, ports_en)
      int_n <= ~sec;
      sel <= i[1:0];
      lock <= (dly == 0);
      hub_n <= 1'h1;
      wait_st(3'h1, 8);
      `CHK("rom", 1'h1, rom_ld)
      hms_host_model_i.wr(hms_pkg::ADDR_CTRL, 32'h1, rsp);
      `CHK("init wr", hms_pkg::RESP_SLVERR, rsp)
      if (dly != 0) begin
        wait_st(3'h2, IC + 4);
        hms_host_model_i.wr(hms_pkg::ADDR_CTRL, 32'h1, rsp);
        `CHK("wait wr", hms_pkg::RESP_SLVERR, rsp)
        repeat (dly) @(posedge clk);
        `CHK("wait", 3'h2, stage)
        lock <= 1'h1;
      end
      wait_st(3'h3, IC + 8);
      int_n <= 1'h1;
      `CHK("freq", ef(sec, i[1:0]), freq)
      if (i % 2 == 1) begin
        hms_host_model_i.wr(hms_pkg::ADDR_CTRL, 32'h3, rsp);
        `CHK("hold wr", hms_pkg::RESP_OKAY, rsp)
        hms_host_model_i.wr(8'h10, 32'h0, rsp);
        `CHK("bad wr", hms_pkg::RESP_SLVERR, rsp)
        repeat (CC + 8) @(posedge clk);
        hms_host_model_i.rd(hms_pkg::ADDR_STATUS, d, rsp);
        `CHK("status", {1'h1, sec, i[1:0], 3'h3}, {d[7:4], d[2:0]})
        hms_host_model_i.wr(hms_pkg::ADDR_CTRL, 32'h2, rsp);
        wait_st(3'h4, 6);
        repeat (dly + 4) @(posedge clk);
        hms_host_model_i.rd(8'h20, d, rsp);
        `CHK("bad rd", {hms_pkg::RESP_SLVERR, 32'h0}, {rsp, d})
        `CHK("connect", 3'h4, stage)
        hms_host_model_i.wr(hms_pkg::ADDR_CTRL, 32'h6, rsp);
        wait_st(3'h5, 2000);
      end else begin
        hms_host_model_i.rd(hms_pkg::ADDR_CTRL, d, rsp);
        `CHK("ctrl", hms_pkg::CTRL_RESET, d)
        repeat (CC - 10) @(posedge clk);
        `CHK("cfg", 3'h3, stage)
        wait_st(3'h5, 16);
      end
      `CHK("ports on", 1'h1, ports_en)
      repeat ($urandom_range(5, 30)) @(posedge clk);
      `CHK("comm", 3'h5, stage)
      hub_n <= 1'h0;
      lock <= 1'h0;
      wait_st(3'h0, 6);
      `CHK("ports off", 1'h0, ports_en)
      $display("run %0d done", i);
    end
    wrap_up();
  end
endmodule // hms_sequencer_tb_top
